// ### design/sector_protection_manager.sv
// sector protection manager: per-sector persistent and volatile guard bits,
// persistent bit lock, one-time mode selection and password unlock
// assumes the serial command decoder presents one decoded command per pulse
// and keeps storage for nonvolatile bits in flip-flops (model of the array)
`timescale 1ns/1ps
`include "sector_guard_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - sector is protected if range protection or sector scheme protects it.
// - one persistent and one volatile bit per sector; either 0 protects.
// - persistent mode sets the lock to 1 at hardware reset.
// - persistent mode: lock clear command clears lock; nothing sets it again.
// - password mode clears the lock to 0 at hardware reset.
// - hidden 64-bit password; exact match sets the lock to 1.
// - password mode also accepts the lock clear command.
// - lock method comes from one-time mode bits, permanent once set.
// - blank part behaves as persistent mode with all sectors unprotected.
// - mode 11 default persistent, 10 persistent, 01 password.
// - programming mode bits to 00 is illegal and reports failure.
// - once a mode is chosen, further mode register writes are rejected.
// - mode register programming takes a page time with busy shown.
// - persistent bits program singly to 0, erase together to 1.
// - with lock at 0, persistent bit program or erase fails unchanged.
// - erase preprogramming and verify happen internally.
// - bit program takes page time, erase takes sector-erase time, busy shown.
// - read command returns the addressed persistent bit.
// - volatile bit only matters when the persistent bit is 1.
// - volatile write clears or sets a sector bit, any number of times.
// - volatile bit exchanged as a byte, 00h protected, ffh unprotected.
// - password mismatch sets error, keeps busy, lock stays 0.
// - failed unlock inserts a 100 us delay before the next attempt.
// - software reset leaves the lock unchanged.
module sector_protection_manager (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic sw_reset,
   input wire logic cmd_valid,
   input wire sector_guard_pkg::guard_cmd_t cmd_code,
   input wire logic [`SG_ADDR_W-1:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   input wire logic [`SG_PASSWORD_W-1:0] cmd_password,
   input wire logic [1:0] cmd_mode_bits,
   input wire logic [`SG_PASSWORD_W-1:0] stored_password,
   input wire logic [1:0] mode_init_bits,
   input wire logic range_protect_hit,
   input wire logic arr_req_valid,
   input wire logic [`SG_ADDR_W-1:0] arr_req_addr,
   output logic arr_req_allowed,
   output logic arr_req_denied,
   output logic cmd_ready,
   output logic write_in_progress,
   output logic program_error,
   output logic persistent_bit_lock,
   output logic [1:0] guard_mode_register,
   output logic rd_valid,
   output logic [7:0] rd_data
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // sector index from a byte address, used for commands and array requests
   function automatic logic [`SG_SECTOR_IDX_W-1:0] sector_of(input logic [`SG_ADDR_W-1:0] a);
      sector_of = a[`SG_SECTOR_LSB +: `SG_SECTOR_IDX_W];
   endfunction

   // mode 11 and 10 both run persistent; only 01 runs password
   function automatic logic is_password_mode(input logic [1:0] m);
      is_password_mode = (m == `SG_MODE_PASSWORD);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [`SG_NUM_SECTORS-1:0] persist_bits_reg;
   logic [`SG_NUM_SECTORS-1:0] volatile_bits_reg;
   logic [1:0] mode_reg;
   logic mode_loaded_reg;
   logic lock_reg;
   logic lock_init_reg;
   logic error_reg;
   sector_guard_pkg::guard_state_t state_reg;
   sector_guard_pkg::guard_cmd_t op_reg;
   logic [`SG_SECTOR_IDX_W-1:0] op_sector_reg;
   logic [1:0] op_mode_reg;
   logic rd_valid_reg;
   logic [7:0] rd_data_reg;
   logic allowed_reg;
   logic denied_reg;

   ////////////////////////////////////////////////////////////////////////////
   // command decode

   wire idle = (state_reg == sector_guard_pkg::st_idle);
   wire take = cmd_valid && idle && lock_init_reg;
   wire [`SG_SECTOR_IDX_W-1:0] cmd_sector = sector_of(cmd_addr);
   wire pw_mode = is_password_mode(mode_reg);
   wire mode_chosen = (mode_reg != `SG_MODE_NONE);
   wire do_pb_prog = take && (cmd_code == sector_guard_pkg::cmd_persistent_bit_program);
   wire do_pb_erase = take && (cmd_code == sector_guard_pkg::cmd_persistent_bit_erase);
   wire do_pb_read = take && (cmd_code == sector_guard_pkg::cmd_persistent_bit_read);
   wire do_lock_clear = take && (cmd_code == sector_guard_pkg::cmd_lock_clear);
   wire do_unlock = take && (cmd_code == sector_guard_pkg::cmd_password_unlock);
   wire do_mode_prog = take && (cmd_code == sector_guard_pkg::cmd_mode_program);
   wire do_vb_write = take && (cmd_code == sector_guard_pkg::cmd_volatile_bit_write);
   wire do_vb_read = take && (cmd_code == sector_guard_pkg::cmd_volatile_bit_read);

   // persistent bit changes need the lock at 1; otherwise fail, bits untouched
   wire pb_blocked = (do_pb_prog || do_pb_erase) && !lock_reg;
   // mode register: one-time, and 00 is an illegal target
   wire mode_reject = do_mode_prog && (mode_chosen || cmd_mode_bits == `SG_MODE_ILLEGAL);
   // unlock only compares in password mode; exact 64-bit match
   wire pw_match = (cmd_password == stored_password);
   wire unlock_fail = do_unlock && (!pw_mode || !pw_match);
   wire start_fail = pb_blocked || mode_reject;
   wire start_busy = (do_pb_prog || do_pb_erase) && lock_reg || do_mode_prog && !mode_reject
                     || do_unlock;

   // busy length per operation
   logic [`SG_CNT_W-1:0] busy_len;
   assign busy_len = do_pb_erase ? `SG_CNT_W'(`SG_SECTOR_ERASE_CYC) :
                     do_unlock ? (unlock_fail ? `SG_CNT_W'(`SG_UNLOCK_DELAY_CYC) : `SG_CNT_W'(1)) :
                     `SG_CNT_W'(`SG_PAGE_PROG_CYC);

   wire timer_done;

   busy_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .load(start_busy || start_fail),
      .load_value(busy_len),
      .done(timer_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // array request protection check

   wire [`SG_SECTOR_IDX_W-1:0] req_sector = sector_of(arr_req_addr);
   // volatile bit only counts where the persistent bit is 1; either 0 protects
   wire sector_guarded = !persist_bits_reg[req_sector] || !volatile_bits_reg[req_sector];
   wire req_protected = range_protect_hit || sector_guarded;

   // registered verdict one cycle after the request
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         allowed_reg <= 1'b0;
         denied_reg <= 1'b0;
      end else if (clk_en) begin
         allowed_reg <= arr_req_valid && !req_protected;
         denied_reg <= arr_req_valid && req_protected;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode register: loaded from the one-time bits after reset release

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_reg <= `SG_MODE_NONE;
         mode_loaded_reg <= 1'b0;
      end else if (clk_en) begin
         if (!mode_loaded_reg) begin
            mode_reg <= mode_init_bits;
            mode_loaded_reg <= 1'b1;
         end else if (state_reg == sector_guard_pkg::st_busy && timer_done
                      && op_reg == sector_guard_pkg::cmd_mode_program) begin
            mode_reg <= op_mode_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // persistent bit lock; software reset deliberately not an input here

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lock_reg <= 1'b0;
         lock_init_reg <= 1'b0;
      end else if (clk_en) begin
         if (mode_loaded_reg && !lock_init_reg) begin
            // reset value depends on the mode, so set one cycle after it loads
            lock_reg <= !is_password_mode(mode_reg);
            lock_init_reg <= 1'b1;
         end else if (do_lock_clear) begin
            lock_reg <= 1'b0;
         end else if (state_reg == sector_guard_pkg::st_busy && timer_done
                      && op_reg == sector_guard_pkg::cmd_password_unlock) begin
            lock_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operation sequencer

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= sector_guard_pkg::st_idle;
         op_reg <= sector_guard_pkg::cmd_none;
         op_sector_reg <= '0;
         op_mode_reg <= `SG_MODE_NONE;
      end else if (clk_en) begin
         case (state_reg)
            sector_guard_pkg::st_idle: begin
               if (start_busy && !unlock_fail) begin
                  state_reg <= sector_guard_pkg::st_busy;
                  op_reg <= cmd_code;
                  op_sector_reg <= cmd_sector;
                  op_mode_reg <= cmd_mode_bits;
               end else if (start_fail || unlock_fail) begin
                  // failed attempts hold busy for the penalty time
                  state_reg <= sector_guard_pkg::st_fail_hold;
                  op_reg <= cmd_code;
               end
            end
            sector_guard_pkg::st_busy, sector_guard_pkg::st_fail_hold: begin
               if (timer_done) begin
                  state_reg <= sector_guard_pkg::st_idle;
               end
            end
            default: begin
               state_reg <= sector_guard_pkg::st_idle;
            end
         endcase
      end
   end

   // program error flag: set on a failed start, cleared by the next accepted command
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         error_reg <= 1'b0;
      end else if (clk_en) begin
         if (start_fail || unlock_fail) begin
            error_reg <= 1'b1;
         end else if (take || sw_reset) begin
            error_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // persistent bits: program one to 0 at completion, erase all to 1

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         persist_bits_reg <= {`SG_NUM_SECTORS{1'b1}};
      end else if (clk_en && state_reg == sector_guard_pkg::st_busy && timer_done) begin
         if (op_reg == sector_guard_pkg::cmd_persistent_bit_program) begin
            persist_bits_reg[op_sector_reg] <= 1'b0;
         end else if (op_reg == sector_guard_pkg::cmd_persistent_bit_erase) begin
            persist_bits_reg <= {`SG_NUM_SECTORS{1'b1}};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // volatile bits: written whenever the sequencer is idle, reset to unprotected

   always_ff @(posedge clk) begin
      if (!rst_n || (clk_en && sw_reset)) begin
         volatile_bits_reg <= {`SG_NUM_SECTORS{1'b1}};
      end else if (clk_en && do_vb_write) begin
         volatile_bits_reg[cmd_sector] <= (cmd_data == `SG_VBYTE_UNPROT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read back: one byte, one cycle after the command

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg <= 8'h00;
      end else if (clk_en) begin
         rd_valid_reg <= do_pb_read || do_vb_read;
         if (do_pb_read) begin
            rd_data_reg <= persist_bits_reg[cmd_sector] ? `SG_VBYTE_UNPROT : `SG_VBYTE_PROT;
         end else if (do_vb_read) begin
            rd_data_reg <= volatile_bits_reg[cmd_sector] ? `SG_VBYTE_UNPROT : `SG_VBYTE_PROT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign cmd_ready = idle && lock_init_reg;
   assign write_in_progress = !idle;
   assign program_error = error_reg;
   assign persistent_bit_lock = lock_reg;
   assign guard_mode_register = mode_reg;
   assign rd_valid = rd_valid_reg;
   assign rd_data = rd_data_reg;
   assign arr_req_allowed = allowed_reg;
   assign arr_req_denied = denied_reg;

endmodule

// ### shared/sector_guard_consts.svh
// constants for the sector protection manager: sector count, mode codes, timing
// assumes a 100 MHz clock; long times become cycle counts here
`ifndef SECTOR_GUARD_CONSTS_SVH
`define SECTOR_GUARD_CONSTS_SVH

`define SG_NUM_SECTORS 64
`define SG_SECTOR_IDX_W 6
`define SG_ADDR_W 24
`define SG_SECTOR_LSB 18
`define SG_PASSWORD_W 64
`define SG_CLK_MHZ 100
// mode lock bits [2:1]
`define SG_MODE_NONE 2'b11
`define SG_MODE_PERSIST 2'b10
`define SG_MODE_PASSWORD 2'b01
`define SG_MODE_ILLEGAL 2'b00
// volatile bit byte codes
`define SG_VBYTE_PROT 8'h00
`define SG_VBYTE_UNPROT 8'hff
// times in microseconds
`define SG_PAGE_PROG_US 250
`define SG_SECTOR_ERASE_US 2000
`define SG_UNLOCK_DELAY_US 100
`define SG_PAGE_PROG_CYC (`SG_PAGE_PROG_US * `SG_CLK_MHZ)
`define SG_SECTOR_ERASE_CYC (`SG_SECTOR_ERASE_US * `SG_CLK_MHZ)
`define SG_UNLOCK_DELAY_CYC (`SG_UNLOCK_DELAY_US * `SG_CLK_MHZ)
`define SG_CNT_W 20

`endif

// ### shared/sector_guard_pkg.sv
// types for the sector protection manager
// constants live in sector_guard_consts.svh
package sector_guard_pkg;

   typedef enum logic [3:0] {
      cmd_none,
      cmd_persistent_bit_program,
      cmd_persistent_bit_erase,
      cmd_persistent_bit_read,
      cmd_lock_clear,
      cmd_password_unlock,
      cmd_mode_program,
      cmd_volatile_bit_write,
      cmd_volatile_bit_read
   } guard_cmd_t;

   typedef enum logic [2:0] {
      st_idle,
      st_busy,
      st_fail_hold
   } guard_state_t;

endpackage

// ### design/busy_timer.sv
// busy timer: counts a loaded number of cycles down to zero
// assumes clk/rst_n/clk_en shared with the parent
`timescale 1ns/1ps
`include "sector_guard_consts.svh"

module busy_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic load,
   input wire logic [`SG_CNT_W-1:0] load_value,
   output logic done
);

   logic [`SG_CNT_W-1:0] count_reg;
   logic [`SG_CNT_W-1:0] count_next;

   // load wins over counting so a fresh operation always restarts the wait
   assign count_next = load ? load_value :
                       (count_reg != '0) ? count_reg - `SG_CNT_W'(1) : count_reg;
   assign done = (count_reg == `SG_CNT_W'(1)) && !load;

   // counter register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (clk_en) begin
         count_reg <= count_next;
      end
   end

endmodule

// ### tb/sector_protection_manager_monitor.sv
// checker for the sector protection manager: port-level timing of verdicts,
// lock, mode register, busy and read answers; bound to the design top
`timescale 1ns/1ps
`include "sector_guard_consts.svh"
module sector_protection_manager_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic cmd_valid,
   input wire sector_guard_pkg::guard_cmd_t cmd_code,
   input wire logic [`SG_PASSWORD_W-1:0] cmd_password,
   input wire logic [`SG_PASSWORD_W-1:0] stored_password,
   input wire logic range_protect_hit,
   input wire logic arr_req_valid,
   input wire logic arr_req_allowed,
   input wire logic arr_req_denied,
   input wire logic cmd_ready,
   input wire logic write_in_progress,
   input wire logic persistent_bit_lock,
   input wire logic [1:0] guard_mode_register,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a command is taken only with ready and the clock enabled
   logic take;
   logic pw_ok;
   assign take = cmd_valid && cmd_ready && clk_en;
   assign pw_ok = cmd_password == stored_password;
   ////////////////////////////////////////////////////////////////////////////
   property p_verdict; arr_req_valid && clk_en |=> arr_req_allowed != arr_req_denied; endproperty
   a_verdict: assert property (p_verdict) else $error("no single verdict");
   property p_range; arr_req_valid && clk_en && range_protect_hit |=> arr_req_denied; endproperty
   a_range: assert property (p_range) else $error("range hit allowed");
   property p_clear; take && cmd_code == sector_guard_pkg::cmd_lock_clear |=> !persistent_bit_lock; endproperty
   a_clear: assert property (p_clear) else $error("lock not cleared");
   // in persistent mode nothing may bring the lock back once ready
   property p_no_set; cmd_ready && !persistent_bit_lock && guard_mode_register != `SG_MODE_PASSWORD
      |=> !persistent_bit_lock; endproperty
   a_no_set: assert property (p_no_set) else $error("lock set again");
   property p_fixed; cmd_ready && guard_mode_register != `SG_MODE_NONE |=> $stable(guard_mode_register); endproperty
   a_fixed: assert property (p_fixed) else $error("mode changed");
   property p_legal; guard_mode_register != `SG_MODE_ILLEGAL; endproperty
   a_legal: assert property (p_legal) else $error("mode 00 stored");
   property p_busy; take && cmd_code inside {sector_guard_pkg::cmd_persistent_bit_program,
      sector_guard_pkg::cmd_persistent_bit_erase, sector_guard_pkg::cmd_mode_program} |=> write_in_progress [*8]; endproperty
   a_busy: assert property (p_busy) else $error("busy not shown");
   property p_bad_pw; take && cmd_code == sector_guard_pkg::cmd_password_unlock && !pw_ok
      |=> (write_in_progress && !persistent_bit_lock) [*8]; endproperty
   a_bad_pw: assert property (p_bad_pw) else $error("mismatch handled wrong");
   property p_good_pw; take && cmd_code == sector_guard_pkg::cmd_password_unlock && pw_ok
      && guard_mode_register == `SG_MODE_PASSWORD |-> ##[1:3] persistent_bit_lock; endproperty
   a_good_pw: assert property (p_good_pw) else $error("match did not unlock");
   property p_read; take && cmd_code inside {sector_guard_pkg::cmd_volatile_bit_read,
      sector_guard_pkg::cmd_persistent_bit_read} |=> rd_valid && (rd_data == 8'h00 || rd_data == 8'hff); endproperty
   a_read: assert property (p_read) else $error("bad read answer");
   // main scenarios reached
   c_deny: cover property (arr_req_denied);
   c_unlock: cover property ($rose(persistent_bit_lock) && guard_mode_register == `SG_MODE_PASSWORD);
   c_busy: cover property ($fell(write_in_progress));
endmodule
bind sector_protection_manager sector_protection_manager_monitor i_sector_protection_manager_monitor (.clk, .rst_n,
   .clk_en, .cmd_valid, .cmd_code, .cmd_password, .stored_password, .range_protect_hit, .arr_req_valid,
   .arr_req_allowed, .arr_req_denied, .cmd_ready, .write_in_progress, .persistent_bit_lock, .guard_mode_register,
   .rd_valid, .rd_data);

// ### tb/guard_host_model.sv
// host model: issues one decoded protection command at a time, then waits out busy
// assumes the device takes a command at an edge where cmd_ready is high
`timescale 1ns/1ps
`include "sector_guard_consts.svh"
module guard_host_model (
   input wire logic clk,
   input wire logic cmd_ready,
   input wire logic write_in_progress,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   output logic cmd_valid,
   output sector_guard_pkg::guard_cmd_t cmd_code,
   output logic [`SG_ADDR_W-1:0] cmd_addr,
   output logic [7:0] cmd_data,
   output logic [`SG_PASSWORD_W-1:0] cmd_password,
   output logic [1:0] cmd_mode_bits,
   output logic [7:0] last_rd
);
   // idle lines at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_code = sector_guard_pkg::cmd_none;
      cmd_addr = 24'h0;
      cmd_data = 8'h0;
      cmd_password = 64'h0;
      cmd_mode_bits = 2'b11;
      last_rd = 8'h0;
   end
   // one command; address, data and password lines are inverted on release so stale values cannot pass
   task automatic issue(input sector_guard_pkg::guard_cmd_t code, input logic [5:0] sector,
      input logic [7:0] data, input logic [63:0] pw = 64'h0, input logic [1:0] mode = 2'b11);
      int n;
      n = 0;
      @(negedge clk);
      while (cmd_ready !== 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      cmd_addr <= {sector, 18'h0};
      cmd_data <= data;
      cmd_password <= pw;
      cmd_mode_bits <= mode;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code <= sector_guard_pkg::cmd_none;
      cmd_addr <= ~cmd_addr;
      cmd_data <= ~cmd_data;
      cmd_password <= ~cmd_password;
      repeat (2) begin
         @(negedge clk);
         if (rd_valid === 1'b1) last_rd = rd_data;
      end
      n = 0;
      while (write_in_progress === 1'b1 && n < 250000) begin
         @(negedge clk);
         n++;
      end
   endtask
endmodule

// ### tb/sector_protection_manager_tb.sv
// testbench: persistent mode, volatile bits, lock and password mode
// assumes one 100 MHz clock; erase is left to the checker because of its length
`timescale 1ns/1ps
`include "sector_guard_consts.svh"
module sector_protection_manager_tb;
   localparam logic [63:0] key = 64'h0123456789abcdef; // arbitrary password
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sw_reset = 1'b0;
   logic range_protect_hit = 1'b0;
   logic arr_req_valid = 1'b0;
   logic [23:0] arr_req_addr = 24'h0;
   logic [1:0] mode_init_bits = 2'b11;
   logic cmd_valid, arr_req_allowed, arr_req_denied, cmd_ready, write_in_progress;
   logic program_error, persistent_bit_lock, rd_valid;
   sector_guard_pkg::guard_cmd_t cmd_code;
   logic [23:0] cmd_addr;
   logic [7:0] cmd_data, rd_data, last_rd;
   logic [63:0] cmd_password;
   logic [1:0] cmd_mode_bits, guard_mode_register;
   int failures = 0;
   int checks_done = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   sector_protection_manager i_sector_protection_manager (.clk, .rst_n, .clk_en(1'b1), .sw_reset, .cmd_valid,
      .cmd_code, .cmd_addr, .cmd_data, .cmd_password, .cmd_mode_bits, .stored_password(key), .mode_init_bits,
      .range_protect_hit, .arr_req_valid, .arr_req_addr, .arr_req_allowed, .arr_req_denied, .cmd_ready,
      .write_in_progress, .program_error, .persistent_bit_lock, .guard_mode_register, .rd_valid, .rd_data);
   guard_host_model i_guard_host_model (.clk, .cmd_ready, .write_in_progress, .rd_valid, .rd_data, .cmd_valid,
      .cmd_code, .cmd_addr, .cmd_data, .cmd_password, .cmd_mode_bits, .last_rd);
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // hardware reset for 10 cycles, then let the two start-up edges pass
   task automatic do_reset(input logic [1:0] mode);
      @(posedge clk);
      rst_n <= 1'b0;
      mode_init_bits <= mode;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // one array request; the verdict pulse is looked at one cycle later
   // the range hit travels with the request so it changes only on a rising edge
   task automatic probe(input logic [5:0] sector, input logic range, input logic deny);
      @(posedge clk);
      arr_req_valid <= 1'b1;
      arr_req_addr <= {sector, 18'h0};
      range_protect_hit <= range;
      @(posedge clk);
      arr_req_valid <= 1'b0;
      arr_req_addr <= ~arr_req_addr;
      range_protect_hit <= 1'b0;
      @(negedge clk);
      chk(arr_req_denied, deny);
      chk(arr_req_allowed, !deny);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence; runs about 85k cycles, mostly page-time busy periods
   initial begin
      do_reset(`SG_MODE_NONE);
      chk(persistent_bit_lock, 1'b1);
      chk(guard_mode_register, `SG_MODE_NONE);
      probe(6'h05, 1'b0, 1'b0);
      probe(6'h05, 1'b1, 1'b1);
      i_guard_host_model.issue(sector_guard_pkg::cmd_volatile_bit_write, 6'h03, `SG_VBYTE_PROT);
      i_guard_host_model.issue(sector_guard_pkg::cmd_volatile_bit_read, 6'h03, 8'h0);
      chk(last_rd, `SG_VBYTE_PROT);
      probe(6'h03, 1'b0, 1'b1);
      i_guard_host_model.issue(sector_guard_pkg::cmd_volatile_bit_write, 6'h03, `SG_VBYTE_UNPROT);
      probe(6'h03, 1'b0, 1'b0);
      $display("test volatile done");
      i_guard_host_model.issue(sector_guard_pkg::cmd_persistent_bit_program, 6'h05, 8'h0);
      i_guard_host_model.issue(sector_guard_pkg::cmd_persistent_bit_read, 6'h05, 8'h0);
      chk(last_rd, 8'h00);
      probe(6'h05, 1'b0, 1'b1);
      i_guard_host_model.issue(sector_guard_pkg::cmd_lock_clear, 6'h0, 8'h0);
      chk(persistent_bit_lock, 1'b0);
      @(posedge clk);
      sw_reset <= 1'b1;
      @(posedge clk);
      sw_reset <= 1'b0;
      @(negedge clk);
      chk(persistent_bit_lock, 1'b0);
      i_guard_host_model.issue(sector_guard_pkg::cmd_persistent_bit_program, 6'h06, 8'h0);
      chk(program_error, 1'b1);
      i_guard_host_model.issue(sector_guard_pkg::cmd_persistent_bit_read, 6'h06, 8'h0);
      chk(last_rd, 8'hff);
      $display("test persistent done");
      // the password is fixed at the stored_password pin before mode 01 applies
      do_reset(`SG_MODE_PASSWORD);
      chk(persistent_bit_lock, 1'b0);
      chk(guard_mode_register, `SG_MODE_PASSWORD);
      i_guard_host_model.issue(sector_guard_pkg::cmd_password_unlock, 6'h0, 8'h0, ~key);
      chk(program_error, 1'b1);
      chk(persistent_bit_lock, 1'b0);
      i_guard_host_model.issue(sector_guard_pkg::cmd_password_unlock, 6'h0, 8'h0, key);
      chk(persistent_bit_lock, 1'b1);
      i_guard_host_model.issue(sector_guard_pkg::cmd_lock_clear, 6'h0, 8'h0);
      chk(persistent_bit_lock, 1'b0);
      i_guard_host_model.issue(sector_guard_pkg::cmd_mode_program, 6'h0, 8'h0, 64'h0, `SG_MODE_PERSIST);
      chk(program_error, 1'b1);
      chk(guard_mode_register, `SG_MODE_PASSWORD);
      $display("test password done");
      tally_and_finish();
   end
   // watchdog, about a sixth above the expected run length of some 85k cycles
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule
